// [design/tss_ctrl.sv]
`timescale 1ns/1ps
`include "tss_consts.svh"
module tss_ctrl #(
  parameter logic [23:0] CONV_CYC = 24'(`TSS_CONV_CYC),
  parameter logic [23:0] IDLE_UNIT_CYC = 24'(`TSS_CONV_CYC)
) (
  // Clocks and reset
  input wire logic I_CLK,
  input wire logic I_SMB_CLK,
  input wire logic I_ARST_N,
  // Standby pin
  input wire logic I_STANDBY_PIN_N,
  // Serial bus pins
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  // Converter
  input wire logic [7:0] I_ADC_DATA,
  output logic O_ADC_EN,
  output logic O_ADC_CHAN,
  output logic O_RES_CANCEL,
  // Status
  output logic O_BUSY,
  output logic O_STANDBY
);
  import tss_pkg::*;

  localparam logic [23:0] HALF_CYC = CONV_CYC >> 1;

  tss_core_t c_q;
  tss_core_t c_d;
  tss_smb_t s_q;
  tss_smb_t s_d;

  // Combinational views of the registered state
  logic hw_standby_pin_n;
  logic halt;
  logic os_req;
  logic abort;
  tss_bundle_t cur;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rx_byte;
  logic [7:0] rd_val;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Rate field scales the idle gap; zero gives back-to-back runs
  function automatic logic [23:0] idle_cyc(input logic [7:0] rate, input logic [23:0] unit);
    logic [27:0] prod;
    prod = 28'(rate[3:0]) * 28'(unit);
    return prod[23:0];
  endfunction

  function automatic logic [7:0] reg_rd(input logic [7:0] ptr, input tss_bundle_t b);
    logic [7:0] v;
    v = `TSS_UNMAPPED_RD;
    if (ptr == `TSS_CMD_LOCAL) v = b.local_t;
    else if (ptr == `TSS_CMD_REMOTE) v = b.remote_t;
    else if (ptr == `TSS_CMD_STATUS) v = b.status;
    else if (ptr == `TSS_CMD_CFG) v = b.cfg;
    else if (ptr == `TSS_CMD_RATE) v = b.rate;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Conversion sequencer (core clock)
  // ----------------------------------------------------------------
  always_comb begin
    c_d = c_q;
    c_d.stb_m = I_STANDBY_PIN_N;
    c_d.stb_s = c_q.stb_m;
    c_d.wreq_m = s_q.wreq;
    c_d.wreq_s = c_q.wreq_m;
    c_d.wreq_p = c_q.wreq_s;
    c_d.back_m = s_q.back;
    c_d.back_s = c_q.back_m;
    hw_standby_pin_n = ~c_q.stb_s;
    halt = c_q.cfg[`TSS_CFG_HALT_BIT];
    os_req = 1'b0;
    abort = 1'b0;
    // Write event: command and data held stable by the bus side until acked
    if (c_q.wreq_s != c_q.wreq_p) begin
      c_d.wack = c_q.wreq_s;
      if (s_q.wev.cmd == `TSS_CMD_CFG) begin
        c_d.cfg = s_q.wev.data;
      end else if (s_q.wev.cmd == `TSS_CMD_RATE) begin
        c_d.rate = s_q.wev.data & `TSS_RATE_MASK;
      end else if (s_q.wev.cmd == `TSS_CMD_ONESHOT) begin
        os_req = 1'b1;
      end
    end
    unique case (c_q.st)
      CS_IDLE: begin
        // Pin standby blocks one-shot; halt only blocks automatic starts
        if (!hw_standby_pin_n && (os_req || (!halt && c_q.tmr == 24'h0))) begin
          c_d.st = CS_CONV;
          c_d.tmr = CONV_CYC - 24'h1;
          c_d.start_halt = halt;
          c_d.adc_en = 1'b1;
          c_d.adc_chan = 1'b0;
          c_d.busy = 1'b1;
        end else if (c_q.tmr != 24'h0) begin
          c_d.tmr = c_q.tmr - 24'h1;
        end
      end
      CS_CONV: begin
        // A halt already set at start belongs to a one-shot run
        abort = hw_standby_pin_n | (halt & ~c_q.start_halt);
        if (abort) begin
          // Results untouched; pending local sample dropped
          c_d.st = CS_IDLE;
          c_d.adc_en = 1'b0;
          c_d.busy = 1'b0;
          c_d.tmr = idle_cyc(c_q.rate, IDLE_UNIT_CYC);
        end else if (c_q.tmr == 24'h0) begin
          c_d.local_t = c_q.pend_local;
          c_d.remote_t = I_ADC_DATA;
          c_d.st = CS_IDLE;
          c_d.adc_en = 1'b0;
          c_d.adc_chan = 1'b0;
          c_d.busy = 1'b0;
          c_d.tmr = idle_cyc(c_q.rate, IDLE_UNIT_CYC);
        end else begin
          if (c_q.tmr == HALF_CYC) begin
            c_d.pend_local = I_ADC_DATA;
            c_d.adc_chan = 1'b1;
          end
          c_d.tmr = c_q.tmr - 24'h1;
        end
      end
    endcase
    c_d.rcan = c_q.cfg[`TSS_CFG_RCAN_BIT];
    c_d.standby_pin_n_o = hw_standby_pin_n | halt;
    // Publish readable state to the bus side; one snapshot in flight at a time
    cur = '0;
    cur.local_t = c_q.local_t;
    cur.remote_t = c_q.remote_t;
    cur.status[`TSS_STAT_BUSY_BIT] = c_q.busy;
    cur.cfg = c_q.cfg;
    cur.rate = c_q.rate;
    if (c_q.breq == c_q.back_s && cur != c_q.shadow) begin
      c_d.shadow = cur;
      c_d.breq = ~c_q.breq;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      c_q <= '0;
      // Synchronisers start at the released pin level: no false standby
      c_q.stb_m <= 1'b1;
      c_q.stb_s <= 1'b1;
      c_q.st <= CS_IDLE;
      c_q.cfg <= `TSS_CFG_RST;
      c_q.rate <= `TSS_RATE_RST;
      c_q.local_t <= `TSS_TEMP_RST;
      c_q.remote_t <= `TSS_TEMP_RST;
      c_q.shadow.cfg <= `TSS_CFG_RST;
      c_q.shadow.rate <= `TSS_RATE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial slave (bus sampling clock)
  // ----------------------------------------------------------------
  assign scl_rise = s_q.scl_s & ~s_q.scl_p;
  assign scl_fall = ~s_q.scl_s & s_q.scl_p;
  assign start_c = s_q.scl_s & s_q.scl_p & s_q.sda_p & ~s_q.sda_s;
  assign stop_c = s_q.scl_s & s_q.scl_p & ~s_q.sda_p & s_q.sda_s;
  assign rx_byte = {s_q.sh[6:0], s_q.sda_s};
  // Selected register as the bus side last saw it
  assign rd_val = reg_rd(s_q.ptr, s_q.bnd);

  always_comb begin
    s_d = s_q;
    s_d.scl_m = I_SCL;
    s_d.scl_s = s_q.scl_m;
    s_d.scl_p = s_q.scl_s;
    s_d.sda_m = I_SDA;
    s_d.sda_s = s_q.sda_m;
    s_d.sda_p = s_q.sda_s;
    s_d.wack_m = c_q.wack;
    s_d.wack_s = s_q.wack_m;
    s_d.breq_m = c_q.breq;
    s_d.breq_s = s_q.breq_m;
    s_d.breq_p = s_q.breq_s;
    // Snapshot stays stable in the core until acknowledged
    if (s_q.breq_s != s_q.breq_p) begin
      s_d.bnd = c_q.shadow;
      s_d.back = s_q.breq_s;
    end
    if (stop_c) begin
      s_d.st = SS_IDLE;
      s_d.oe = 1'b0;
      // Events dropped if the previous one is still crossing
      if (s_q.wreq == s_q.wack_s && s_q.nbytes != 2'd0) begin
        if (s_q.nbytes == 2'd2 || s_q.ptr == `TSS_CMD_ONESHOT) begin
          s_d.wev.cmd = s_q.ptr;
          s_d.wev.data = s_q.data;
          s_d.wreq = ~s_q.wreq;
        end
      end
    end else if (start_c) begin
      // Repeated start keeps the pointer for the read phase
      s_d.st = SS_RX;
      s_d.oe = 1'b0;
      s_d.cnt = 3'd0;
      s_d.addr_ph = 1'b1;
      s_d.nbytes = 2'd0;
    end else begin
      unique case (s_q.st)
        SS_IDLE, SS_WAIT: begin
          s_d.oe = 1'b0;
        end
        SS_RX: begin
          if (scl_rise) begin
            s_d.sh = rx_byte;
            s_d.cnt = s_q.cnt + 3'd1;
            if (s_q.cnt == 3'd7) begin
              s_d.st = SS_ACKW;
              if (s_q.addr_ph) begin
                s_d.is_rd = rx_byte[0];
                s_d.addr_ph = 1'b0;
                if (rx_byte[7:1] != `TSS_SLAVE_ADDR) begin
                  s_d.st = SS_WAIT;
                end
              end else if (s_q.nbytes == 2'd0) begin
                s_d.ptr = rx_byte;
                s_d.nbytes = 2'd1;
              end else if (s_q.nbytes == 2'd1) begin
                s_d.data = rx_byte;
                s_d.nbytes = 2'd2;
              end else begin
                // Longer writes are not a supported protocol: no ack
                s_d.st = SS_WAIT;
              end
            end
          end
        end
        SS_ACKW: begin
          if (scl_fall) begin
            s_d.oe = 1'b1;
            s_d.st = SS_ACK;
          end
        end
        SS_ACK: begin
          if (scl_fall) begin
            s_d.cnt = 3'd0;
            if (s_q.is_rd) begin
              // Receive Byte and Read Byte both return the selected register
              s_d.sh = rd_val;
              s_d.oe = ~rd_val[7];
              s_d.st = SS_TX;
            end else begin
              s_d.oe = 1'b0;
              s_d.st = SS_RX;
            end
          end
        end
        SS_TX: begin
          if (scl_fall) begin
            if (s_q.cnt == 3'd7) begin
              s_d.oe = 1'b0;
              s_d.st = SS_MACK;
            end else begin
              s_d.cnt = s_q.cnt + 3'd1;
              s_d.sh = {s_q.sh[6:0], 1'b0};
              s_d.oe = ~s_q.sh[6];
            end
          end
        end
        SS_MACK: begin
          // Only one data byte per read, whatever the master answers
          if (scl_rise) begin
            s_d.st = SS_WAIT;
          end
        end
        default: begin
          s_d.st = SS_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge I_SMB_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s_q <= '0;
      // Bus lines idle high, so reset makes no false start or edge
      s_q.scl_m <= 1'b1;
      s_q.scl_s <= 1'b1;
      s_q.scl_p <= 1'b1;
      s_q.sda_m <= 1'b1;
      s_q.sda_s <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.st <= SS_IDLE;
      s_q.bnd.cfg <= `TSS_CFG_RST;
      s_q.bnd.rate <= `TSS_RATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_SDA_OUT = 1'b0;
  assign O_SDA_OE = s_q.oe;
  assign O_ADC_EN = c_q.adc_en;
  assign O_ADC_CHAN = c_q.adc_chan;
  assign O_RES_CANCEL = c_q.rcan;
  assign O_BUSY = c_q.busy;
  assign O_STANDBY = c_q.standby_pin_n_o;

endmodule // tss_ctrl

// [design/tss_consts.svh]
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
// Core clock and conversion timing
`define TSS_CLK_HZ 20000000
`define TSS_CONV_TIME_MS 125
`define TSS_CONV_CYC ((`TSS_CONV_TIME_MS) * (`TSS_CLK_HZ / 1000))
// Serial slave address (arbitrary value)
`define TSS_SLAVE_ADDR 7'h2a
// Command codes
`define TSS_CMD_LOCAL 8'h00
`define TSS_CMD_REMOTE 8'h01
`define TSS_CMD_STATUS 8'h02
`define TSS_CMD_CFG 8'h03
`define TSS_CMD_RATE 8'h04
`define TSS_CMD_ONESHOT 8'h0f
// Field positions
`define TSS_CFG_HALT_BIT 6
`define TSS_CFG_RCAN_BIT 4
`define TSS_STAT_BUSY_BIT 7
// Reset values and masks
`define TSS_CFG_RST 8'h00
`define TSS_RATE_RST 8'h00
`define TSS_RATE_MASK 8'h0f
`define TSS_TEMP_RST 8'h00
`define TSS_UNMAPPED_RD 8'h00
`endif

// [design/tss_pkg.sv]
package tss_pkg;
`include "tss_consts.svh"

  typedef enum logic [0:0] {
    CS_IDLE = 1'b0,
    CS_CONV = 1'b1
  } tss_cstate_t;

  typedef enum logic [2:0] {
    SS_IDLE = 3'b000,
    SS_RX   = 3'b001,
    SS_ACKW = 3'b010,
    SS_ACK  = 3'b011,
    SS_TX   = 3'b100,
    SS_MACK = 3'b101,
    SS_WAIT = 3'b110
  } tss_sstate_t;

  typedef struct packed {
    logic [7:0] local_t;
    logic [7:0] remote_t;
    logic [7:0] status;
    logic [7:0] cfg;
    logic [7:0] rate;
  } tss_bundle_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } tss_wevt_t;

  typedef struct packed {
    logic stb_m;
    logic stb_s;
    tss_cstate_t st;
    logic [23:0] tmr;
    logic start_halt;
    logic [7:0] local_t;
    logic [7:0] remote_t;
    logic [7:0] pend_local;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic adc_en;
    logic adc_chan;
    logic busy;
    logic standby_pin_n_o;
    logic rcan;
    logic wreq_m;
    logic wreq_s;
    logic wreq_p;
    logic wack;
    logic breq;
    tss_bundle_t shadow;
    logic back_m;
    logic back_s;
  } tss_core_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    tss_sstate_t st;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic addr_ph;
    logic is_rd;
    logic [1:0] nbytes;
    logic [7:0] ptr;
    logic [7:0] data;
    logic oe;
    logic wreq;
    tss_wevt_t wev;
    logic wack_m;
    logic wack_s;
    logic breq_m;
    logic breq_s;
    logic breq_p;
    logic back;
    tss_bundle_t bnd;
  } tss_smb_t;
endpackage

// [tb/tss_ctrl_assertions.sv]
`timescale 1ns/1ps
module tss_ctrl_assertions #(
  parameter logic [23:0] CONV_CYC = 24'h28,
  parameter logic [23:0] IDLE_UNIT_CYC = 24'ha
) (
  // Clocks, reset and pins
  input wire logic I_CLK,
  input wire logic I_SMB_CLK,
  input wire logic I_ARST_N,
  input wire logic I_STANDBY_PIN_N,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic [7:0] I_ADC_DATA,
  // Design outputs
  input wire logic O_SDA_OUT,
  input wire logic O_SDA_OE,
  input wire logic O_ADC_EN,
  input wire logic O_ADC_CHAN,
  input wire logic O_RES_CANCEL,
  input wire logic O_BUSY,
  input wire logic O_STANDBY
);
  // ----
  // Run and idle counters
  // ----
  typedef struct packed {
    logic [23:0] run;
    logic [27:0] idle;
  } tss_chk_t;
  tss_chk_t c_q;
  tss_chk_t c_d;
  always_comb begin
    c_d.run = O_ADC_EN ? c_q.run + 24'h1 : 24'h0;
    c_d.idle = (O_ADC_EN || O_STANDBY) ? 28'h0 : c_q.idle + 28'h1;
  end
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end
  // ----
  // Properties
  // ----
  busy_flag_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_BUSY == O_ADC_EN) else $error("busy flag differs from converter enable");
  pin_standby_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    !I_STANDBY_PIN_N [*6] |-> O_STANDBY) else $error("pin low but no standby");
  pin_blocks_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    !I_STANDBY_PIN_N [*6] |-> !O_ADC_EN) else $error("conversion while pin low");
  seq_length_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    $fell(O_ADC_EN) |-> c_q.run == CONV_CYC || O_STANDBY || !I_STANDBY_PIN_N)
    else $error("sequence ended early without standby");
  seq_bound_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    c_q.run <= CONV_CYC) else $error("sequence too long");
  local_first_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    $rose(O_ADC_EN) |-> !O_ADC_CHAN) else $error("sequence not started on local");
  remote_last_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    $fell(O_ADC_EN) && c_q.run == CONV_CYC |-> $past(O_ADC_CHAN))
    else $error("remote channel not measured");
  idle_bound_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    c_q.idle <= 28'(IDLE_UNIT_CYC) * 28'hf + 28'h8) else $error("idle gap too long");
  ack_timing_a: assert property (@(posedge I_SMB_CLK) disable iff (!I_ARST_N)
    $rose(O_SDA_OE) |-> !I_SCL) else $error("data line taken while clock high");
  open_drain_a: assert property (@(posedge I_SMB_CLK) disable iff (!I_ARST_N)
    O_SDA_OUT == 1'b0) else $error("data line driven high");
endmodule // tss_ctrl_assertions

// [tb/tss_smb_host.sv]
`timescale 1ns/1ps
module tss_smb_host #(
  parameter time Q = 250
) (
  // Bus wires
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // ----
  // Bit level; sole master, so short forms are safe
  // ----
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic bitx(input logic b, output logic r);
    o_sda_low = !b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask
  task automatic bus_start();
    o_sda_low = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda_low = 1'b1;
    #Q o_scl = 1'b0;
    #Q;
  endtask
  task automatic bus_stop();
    o_sda_low = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda_low = 1'b0;
    #Q;
  endtask
  task automatic put(input logic [7:0] v, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    ok = ok && !r;
  endtask
  // Kind 0 write, 1 send, 2 read, 3 receive
  task automatic txn(input logic [6:0] a, input logic [1:0] k, input logic [7:0] c,
      input logic [7:0] d, output logic [7:0] q, output logic ok);
    logic r;
    ok = 1'b1;
    q = 8'h00;
    bus_start();
    put({a, k == 2'h3}, ok);
    if (k != 2'h3) put(c, ok);
    if (k == 2'h0) put(d, ok);
    if (k == 2'h2) begin
      bus_start();
      put({a, 1'b1}, ok);
    end
    if (k[1]) begin
      for (int i = 0; i < 8; i++) begin
        bitx(1'b1, r);
        q = {q[6:0], r};
      end
      bitx(1'b1, r);
    end
    bus_stop();
  endtask
endmodule // tss_smb_host

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "tss_consts.svh"
module testbench;
  localparam logic [23:0] CONV = 24'hbb8;
  localparam logic [23:0] UNIT = 24'h64;
  localparam logic [6:0] A = `TSS_SLAVE_ADDR;
  logic clk = 1'b0;
  logic smb_clk = 1'b0;
  logic arst_n = 1'b0;
  logic pin_n = 1'b1;
  logic [7:0] adc = 8'h00;
  logic [7:0] loc_v = 8'h5a;
  logic [7:0] rem_v = 8'h3c;
  logic host_low, scl, sda_w, sda_out, sda_oe, adc_en, chan, rcan, busy, standby_pin_n;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  always #15 smb_clk = ~smb_clk;
  // Pull-up wins unless someone sinks the line
  assign sda_w = !host_low && !(sda_oe && !sda_out);
  always @(negedge clk) adc <= chan ? rem_v : loc_v;
  tss_ctrl #(.CONV_CYC(CONV), .IDLE_UNIT_CYC(UNIT)) u_tss_ctrl (.I_CLK(clk),
    .I_SMB_CLK(smb_clk), .I_ARST_N(arst_n), .I_STANDBY_PIN_N(pin_n), .I_SCL(scl),
    .I_SDA(sda_w), .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_ADC_DATA(adc),
    .O_ADC_EN(adc_en), .O_ADC_CHAN(chan), .O_RES_CANCEL(rcan), .O_BUSY(busy),
    .O_STANDBY(standby_pin_n));
  tss_smb_host u_host (.i_sda(sda_w), .o_scl(scl), .o_sda_low(host_low));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [6:0] a, input logic [1:0] k, input logic [7:0] c,
      input logic [7:0] d, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    u_host.txn(a, k, c, d, q, ok);
    chk(ok, a == A);
    if (k[1] && ok) chk(q, e);
  endtask
  task automatic wait_en(input logic v, input int lim, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge clk);
      hit = (adc_en === v);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    logic h;
    int g;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (5) @(negedge clk);
    bus(A, 2'h2, `TSS_CMD_CFG, 8'h00, `TSS_CFG_RST);
    bus(A, 2'h0, `TSS_CMD_RATE, 8'hf3, 8'h00);
    bus(A, 2'h2, `TSS_CMD_RATE, 8'h00, 8'hf3 & `TSS_RATE_MASK);
    bus(A, 2'h0, `TSS_CMD_RATE, 8'h00, 8'h00);
    bus(A, 2'h0, `TSS_CMD_CFG, 8'h10, 8'h00);
    repeat (20) @(negedge clk);
    chk(rcan, 1'b1);
    bus(A, 2'h2, `TSS_CMD_CFG, 8'h00, 8'h10);
    $display("test regs done");
    wait_en(1'b1, 4000, h);
    wait_en(1'b0, 4000, h);
    for (g = 0; adc_en !== 1'b1 && g < 99; g++) @(negedge clk);
    chk(8'(g), 8'h01);
    bus(A, 2'h2, `TSS_CMD_LOCAL, 8'h00, 8'h5a);
    bus(A, 2'h2, `TSS_CMD_REMOTE, 8'h00, 8'h3c);
    $display("test auto done");
    bus(A, 2'h0, `TSS_CMD_CFG, 8'h50, 8'h00);
    repeat (20) @(negedge clk);
    chk(standby_pin_n, 1'b1);
    chk(adc_en, 1'b0);
    chk(rcan, 1'b1);
    wait_en(1'b1, 4000, h);
    chk(h, 1'b0);
    loc_v = 8'h11;
    rem_v = 8'h22;
    bus(A, 2'h1, `TSS_CMD_ONESHOT, 8'h00, 8'h00);
    wait_en(1'b1, 200, h);
    chk(h, 1'b1);
    wait_en(1'b0, 4000, h);
    bus(A, 2'h2, `TSS_CMD_LOCAL, 8'h00, 8'h11);
    bus(A, 2'h2, `TSS_CMD_REMOTE, 8'h00, 8'h22);
    $display("test oneshot done");
    loc_v = 8'h77;
    rem_v = 8'h66;
    bus(A, 2'h0, `TSS_CMD_ONESHOT, 8'h00, 8'h00);
    wait_en(1'b1, 200, h);
    repeat (2000) @(negedge clk);
    pin_n = 1'b0;
    repeat (10) @(negedge clk);
    chk(adc_en, 1'b0);
    bus(A, 2'h2, `TSS_CMD_LOCAL, 8'h00, 8'h11);
    bus(A, 2'h2, `TSS_CMD_REMOTE, 8'h00, 8'h22);
    bus(A, 2'h1, `TSS_CMD_ONESHOT, 8'h00, 8'h00);
    wait_en(1'b1, 4000, h);
    chk(h, 1'b0);
    pin_n = 1'b1;
    $display("test abort done");
    bus(A, 2'h2, `TSS_CMD_REMOTE, 8'h00, 8'h22);
    bus(A, 2'h3, 8'h00, 8'h00, 8'h22);
    bus(A, 2'h1, `TSS_CMD_LOCAL, 8'h00, 8'h00);
    bus(A, 2'h3, 8'h00, 8'h00, 8'h11);
    bus(A ^ 7'h01, 2'h2, `TSS_CMD_LOCAL, 8'h00, 8'h00);
    bus(A, 2'h2, 8'h05, 8'h00, `TSS_UNMAPPED_RD);
    $display("test short done");
    bus(A, 2'h0, `TSS_CMD_CFG, 8'h00, 8'h00);
    wait_en(1'b1, 500, h);
    chk(h, 1'b1);
    chk(rcan, 1'b0);
    chk(standby_pin_n, 1'b0);
    bus(A, 2'h2, `TSS_CMD_LOCAL, 8'h00, 8'h11);
    bus(A, 2'h2, `TSS_CMD_STATUS, 8'h00, 8'h80);
    $display("test busy done");
    // Pin alone, halt clear, cuts an automatic run
    pin_n = 1'b0;
    repeat (10) @(negedge clk);
    chk(standby_pin_n, 1'b1);
    chk(adc_en, 1'b0);
    bus(A, 2'h2, `TSS_CMD_LOCAL, 8'h00, 8'h11);
    wait_en(1'b1, 3200, h);
    chk(h, 1'b0);
    $display("test pin done");
    conclude();
  end
endmodule // testbench

bind tss_ctrl tss_ctrl_assertions #(.CONV_CYC(CONV_CYC), .IDLE_UNIT_CYC(IDLE_UNIT_CYC))
  u_tss_ctrl_assertions (.I_CLK(I_CLK), .I_SMB_CLK(I_SMB_CLK), .I_ARST_N(I_ARST_N),
  .I_STANDBY_PIN_N(I_STANDBY_PIN_N), .I_SCL(I_SCL), .I_SDA(I_SDA),
  .I_ADC_DATA(I_ADC_DATA), .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE),
  .O_ADC_EN(O_ADC_EN), .O_ADC_CHAN(O_ADC_CHAN), .O_RES_CANCEL(O_RES_CANCEL),
  .O_BUSY(O_BUSY), .O_STANDBY(O_STANDBY));
